// ==== wdrc_pkg.sv ====
package wdrc_pkg;

   // register bus widths
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_WDT_CTRL = 4'h0;  // watchdog_control
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 4'h1;  // reset_cause_flags
   localparam logic [ADDR_W-1:0] OFS_RST_CTRL = 4'h2;  // guarded_reset_control
   localparam logic [ADDR_W-1:0] OFS_THRESH   = 4'h3;  // threshold_select_register
   localparam logic [ADDR_W-1:0] OFS_QUAL     = 4'h4;  // qualify_time_select
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h5;  // timeout / powerdown status

   // power-on values
   localparam logic [7:0] WDT_CTRL_POR = 8'h53;
   localparam logic [7:0] RST_CTRL_POR = 8'h55;
   localparam logic [7:0] THRESH_POR   = 8'h55;
   localparam logic [1:0] QUAL_POR     = 2'h1;

   // guarded codes
   localparam logic [4:0] WDT_EN_CODE  = 5'h0A;
   localparam logic [4:0] WDT_DIS_CODE = 5'h15;
   localparam logic [7:0] RST_NOP_A    = 8'h55;
   localparam logic [7:0] RST_NOP_B    = 8'hAA;
   localparam logic [7:0] THR_CODE_0   = 8'h55;
   localparam logic [7:0] THR_CODE_1   = 8'h33;
   localparam logic [7:0] THR_CODE_2   = 8'h99;
   localparam logic [7:0] THR_CODE_3   = 8'hAA;

   // field positions
   localparam int unsigned GUARD_MSB = 7;
   localparam int unsigned GUARD_LSB = 3;
   localparam int unsigned PSEL_MSB  = 2;
   localparam int unsigned PSEL_LSB  = 0;
   localparam int unsigned WRF_BIT   = 0;
   localparam int unsigned LRF_BIT   = 1;
   localparam int unsigned LOW_VOLTAGE_RESET_FLAG_BIT  = 2;
   localparam int unsigned RESET_REG_RESET_FLAG_BIT  = 3;
   localparam int unsigned FLAGS_W   = 4;
   localparam int unsigned TO_BIT    = 0;
   localparam int unsigned PDF_BIT   = 1;

   // counter widths
   localparam int unsigned CNT_W  = 18;
   localparam int unsigned QCNT_W = 8;

   // default soft reset delay in slow oscillator ticks
   localparam logic [7:0] SRESET_TICKS_DEF = 8'h10;

   // soft reset sequencer states
   typedef enum logic [1:0] {
      RS_IDLE = 2'b00,
      RS_WAIT = 2'b01,
      RS_FIRE = 2'b10
   } wdrc_rst_state_e;

   // register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } wdrc_bus_s;

   // reset outputs towards the core
   typedef struct packed {
      logic sys_reset;
      logic pc_sp_clear;
      logic port_preset;
   } wdrc_rst_s;

   // last count before overflow for each period select code
   function automatic logic [CNT_W-1:0] period_last(input logic [2:0] sel);
      case (sel)
         3'h0:    period_last = 18'h000FF;
         3'h1:    period_last = 18'h003FF;
         3'h2:    period_last = 18'h00FFF;
         3'h3:    period_last = 18'h03FFF;
         3'h4:    period_last = 18'h07FFF;
         3'h5:    period_last = 18'h0FFFF;
         3'h6:    period_last = 18'h1FFFF;
         default: period_last = 18'h3FFFF;
      endcase
   endfunction

   // last qualify tick index: 8, 32, 64 or 128 ticks of low voltage
   function automatic logic [QCNT_W-1:0] qual_last(input logic [1:0] sel);
      case (sel)
         2'h0:    qual_last = 8'h07;
         2'h1:    qual_last = 8'h1F;
         2'h2:    qual_last = 8'h3F;
         default: qual_last = 8'h7F;
      endcase
   endfunction

   // threshold code check
   function automatic logic thr_valid(input logic [7:0] code);
      thr_valid = (code == THR_CODE_0) || (code == THR_CODE_1) ||
                  (code == THR_CODE_2) || (code == THR_CODE_3);
   endfunction

endpackage

// ==== wdrc_top.sv ====
// Functional notes
// [RULE_01] counter ticks slow oscillator, eight power-two periods
// [RULE_02] enable code runs, disable code stops
// [RULE_03] other enable codes: delayed reset, flag set
// [RULE_04] power-on: enable code, period select 011
// [RULE_05] bit0 flag set by watchdog code reset
// [RULE_06] running overflow: full reset, timeout flag
// [RULE_07] sleep overflow: timeout flag, clear pc/sp
// [RULE_08] count cleared by soft reset, clear, halt
// [RULE_09] reset control codes 55/AA idle, others reset
// [RULE_10] reset control register powers up 55
// [RULE_11] bit3 flag set by reset control reset
// [RULE_12] flags upper bits zero, flags power-up cleared
// [RULE_13] low voltage reset needs qualified persistence
// [RULE_14] qualified low voltage reset sets bit2
// [RULE_15] bad threshold code: delayed reset, flag set
// [RULE_16] low voltage reset off in sleep/idle
// [RULE_17] power-on clears the program counter
// [RULE_18] power-on presets ports to all ones
// [RULE_19] four threshold codes; bad one restores default
// [RULE_20] qualify select: 8, 32, 64, 128 ticks
// [RULE_21] halt clears count, resumes only if enabled
// [RULE_22] soft reset delay is parameterised slow ticks
// [RULE_23] clear/halt pulses, low voltage synchronised level
`timescale 1ns/1ps
module wdrc_top #(
   parameter logic [7:0] SRESET_TICKS = wdrc_pkg::SRESET_TICKS_DEF  // soft reset delay, slow ticks
) (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         clk_en,
   input  wire wdrc_pkg::wdrc_bus_s          bus_i,
   output logic [wdrc_pkg::DATA_W-1:0]       rd_data_o,
   input  wire logic                         slow_osc_i,
   input  wire logic                         low_voltage_i,
   input  wire logic                         sleep_idle_i,
   input  wire logic                         clear_watchdog_instruction_i,
   input  wire logic                         halt_i,
   output wdrc_pkg::wdrc_rst_s               rst_o
);
   import wdrc_pkg::*;

   localparam logic [7:0] SRESET_LAST = 8'(SRESET_TICKS - 8'h01);  // last delay tick index

   // synchroniser stages
   logic                  osc_s1_q;      // oscillator pin, first stage
   logic                  osc_s2_q;      // oscillator, second stage
   logic                  osc_s3_q;      // oscillator, edge history
   logic                  lv_s1_q;       // low voltage pin, first stage
   logic                  lv_s2_q;       // low voltage, synchronised
   // registers
   logic [7:0]            wdt_ctrl_q;    // watchdog_control
   logic [7:0]            rst_ctrl_q;    // guarded_reset_control
   logic [7:0]            thresh_q;      // threshold_select_register
   logic [1:0]            qual_sel_q;    // qualify_time_select
   logic [FLAGS_W-1:0]    flags_q;       // reset_cause_flags
   logic                  to_q;          // timeout_status_flag
   logic                  pdf_q;         // powerdown_status_flag
   // counters and sequencer
   logic [CNT_W-1:0]      wdt_cnt_q;     // watchdog_counter
   logic [QCNT_W-1:0]     lv_cnt_q;      // low voltage persistence count
   wdrc_rst_state_e       srst_state_q;  // soft reset sequencer
   logic [7:0]            srst_cnt_q;    // soft reset delay count
   logic [2:0]            cause_q;       // captured causes: thr, rst, wdt
   logic [DATA_W-1:0]     rd_data_q;     // read data
   wdrc_rst_s             rst_q;         // reset outputs

   // combinational terms
   logic [4:0]            guard_field;   // guard_enable_field
   logic [2:0]            period_sel;    // period_select
   logic                  tick;          // one slow oscillator rising edge
   logic                  wdt_run;       // watchdog enabled
   logic                  wdt_bad;       // invalid enable code
   logic                  rst_bad;       // invalid reset control code
   logic                  thr_bad;       // invalid threshold code
   logic                  wdt_clear_evt; // clear or halt instruction
   logic                  wdt_ovf;       // watchdog overflow this cycle
   logic                  norm_ovf;      // overflow while running
   logic                  sleep_to;      // overflow while asleep
   logic                  lv_active;     // low voltage reset enabled
   logic                  lv_fire;       // qualified low voltage reset
   logic                  sw_fire;       // soft reset fires
   logic                  full_reset;    // any full device reset
   logic                  wr_hit;        // write strobe qualified
   logic [FLAGS_W-1:0]    flag_set;      // hardware flag set terms

   assign guard_field   = wdt_ctrl_q[GUARD_MSB:GUARD_LSB];
   assign period_sel    = wdt_ctrl_q[PSEL_MSB:PSEL_LSB];
   assign tick          = osc_s2_q & ~osc_s3_q;
   assign wdt_run       = (guard_field == WDT_EN_CODE);                               // RULE_02
   assign wdt_bad       = (guard_field != WDT_EN_CODE) && (guard_field != WDT_DIS_CODE); // RULE_03
   assign rst_bad       = (rst_ctrl_q != RST_NOP_A) && (rst_ctrl_q != RST_NOP_B);     // RULE_09
   assign thr_bad       = !thr_valid(thresh_q);                                      // RULE_19
   assign wdt_clear_evt = clear_watchdog_instruction_i | halt_i;                                        // RULE_23
   // clear in the same cycle beats an overflow
   // a count already past a newly shortened period overflows on the next tick
   assign wdt_ovf       = tick && wdt_run && !wdt_clear_evt &&
                          (wdt_cnt_q >= period_last(period_sel));                     // RULE_01
   assign norm_ovf      = wdt_ovf && !sleep_idle_i;                                  // RULE_06
   assign sleep_to      = wdt_ovf && sleep_idle_i;                                   // RULE_07
   assign lv_active     = !sleep_idle_i;                                             // RULE_16
   assign lv_fire       = tick && lv_active && lv_s2_q &&
                          (lv_cnt_q >= qual_last(qual_sel_q));                        // RULE_13
   assign sw_fire       = (srst_state_q == RS_FIRE);
   assign full_reset    = sw_fire | lv_fire | norm_ovf;
   assign wr_hit        = bus_i.wr;
   // cause bits: [2] threshold, [1] reset control, [0] watchdog control
   always_comb
   begin
      flag_set           = '0;
      flag_set[WRF_BIT]  = sw_fire & cause_q[0];  // RULE_05
      flag_set[RESET_REG_RESET_FLAG_BIT] = sw_fire & cause_q[1];  // RULE_11
      flag_set[LRF_BIT]  = sw_fire & cause_q[2];  // RULE_15
      flag_set[LOW_VOLTAGE_RESET_FLAG_BIT] = lv_fire;               // RULE_14
   end

   // slow oscillator pin synchroniser
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end
      else if (clk_en)
      begin
         osc_s1_q <= slow_osc_i;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end

   // low voltage level synchroniser
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         lv_s1_q <= 1'b0;
         lv_s2_q <= 1'b0;
      end
      else if (clk_en)
      begin
         lv_s1_q <= low_voltage_i;  // RULE_23
         lv_s2_q <= lv_s1_q;
      end
   end

   // watchdog control register
   always_ff @(posedge clk)
   begin
      if (reset)
         wdt_ctrl_q <= WDT_CTRL_POR;  // RULE_04
      else if (clk_en)
      begin
         if (full_reset)
            wdt_ctrl_q <= WDT_CTRL_POR;
         else if (wr_hit && bus_i.addr == OFS_WDT_CTRL)
            wdt_ctrl_q <= bus_i.wdata;
      end
   end

   // guarded reset control register
   always_ff @(posedge clk)
   begin
      if (reset)
         rst_ctrl_q <= RST_CTRL_POR;  // RULE_10
      else if (clk_en)
      begin
         if (full_reset)
            rst_ctrl_q <= RST_CTRL_POR;
         else if (wr_hit && bus_i.addr == OFS_RST_CTRL)
            rst_ctrl_q <= bus_i.wdata;
      end
   end

   // threshold select; kept across a low voltage reset
   always_ff @(posedge clk)
   begin
      if (reset)
         thresh_q <= THRESH_POR;
      else if (clk_en)
      begin
         if (sw_fire || norm_ovf)
            thresh_q <= THRESH_POR;  // RULE_19
         else if (wr_hit && bus_i.addr == OFS_THRESH)
            thresh_q <= bus_i.wdata;
      end
   end

   // qualify time select
   always_ff @(posedge clk)
   begin
      if (reset)
         qual_sel_q <= QUAL_POR;
      else if (clk_en)
      begin
         if (full_reset)
            qual_sel_q <= QUAL_POR;
         else if (wr_hit && bus_i.addr == OFS_QUAL)
            qual_sel_q <= bus_i.wdata[1:0];  // RULE_20
      end
   end

   // reset cause flags: writing 0 clears, hardware set wins
   always_ff @(posedge clk)
   begin
      if (reset)
         flags_q <= '0;  // RULE_12
      else if (clk_en)
      begin
         if (wr_hit && bus_i.addr == OFS_FLAGS)
            flags_q <= flag_set | (flags_q & bus_i.wdata[FLAGS_W-1:0]);  // RULE_05
         else
            flags_q <= flag_set | flags_q;  // RULE_11
      end
   end

   // timeout and powerdown status
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         to_q  <= 1'b0;
         pdf_q <= 1'b0;
      end
      else if (clk_en)
      begin
         to_q  <= wdt_ovf | (to_q & ~wdt_clear_evt);         // RULE_06
         pdf_q <= halt_i | sleep_to | (pdf_q & ~clear_watchdog_instruction_i);  // RULE_07
      end
   end

   // watchdog counter
   always_ff @(posedge clk)
   begin
      if (reset)
         wdt_cnt_q <= '0;
      else if (clk_en)
      begin
         if (wdt_clear_evt || full_reset || sleep_to)
            wdt_cnt_q <= '0;  // RULE_08
         else if (tick && wdt_run)
            wdt_cnt_q <= wdt_cnt_q + 18'h00001;  // RULE_21
      end
   end

   // low voltage persistence counter
   always_ff @(posedge clk)
   begin
      if (reset)
         lv_cnt_q <= '0;
      else if (clk_en)
      begin
         if (!lv_s2_q || !lv_active || lv_fire)
            lv_cnt_q <= '0;  // RULE_13
         else if (tick)
            lv_cnt_q <= lv_cnt_q + 8'h01;
      end
   end

   // soft reset sequencer
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         srst_state_q <= RS_IDLE;
         srst_cnt_q   <= '0;
         cause_q      <= '0;
      end
      else if (clk_en)
      begin
         case (srst_state_q)
            RS_IDLE:
            begin
               srst_cnt_q <= '0;
               // a full reset restores valid codes, except the threshold on a low voltage reset, so do not arm on it
               if ((wdt_bad || rst_bad || thr_bad) && !full_reset)
               begin
                  srst_state_q <= RS_WAIT;
                  cause_q      <= {thr_bad, rst_bad, wdt_bad};  // RULE_03
               end
            end
            RS_WAIT:
            begin
               if (lv_fire || norm_ovf)
                  srst_state_q <= RS_IDLE;
               else if (tick && srst_cnt_q == SRESET_LAST)
                  srst_state_q <= RS_FIRE;  // RULE_22
               else if (tick)
                  srst_cnt_q <= srst_cnt_q + 8'h01;
            end
            RS_FIRE:
               srst_state_q <= RS_IDLE;
            default:
               srst_state_q <= RS_IDLE;
         endcase
      end
   end

   // register read port, data one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (reset)
         rd_data_q <= '0;
      else if (clk_en)
      begin
         rd_data_q <= '0;
         if (bus_i.rd)
         begin
            if (bus_i.addr == OFS_WDT_CTRL)
               rd_data_q <= wdt_ctrl_q;
            else if (bus_i.addr == OFS_FLAGS)
               rd_data_q <= {4'h0, flags_q};  // RULE_12
            else if (bus_i.addr == OFS_RST_CTRL)
               rd_data_q <= rst_ctrl_q;
            else if (bus_i.addr == OFS_THRESH)
               rd_data_q <= thresh_q;
            else if (bus_i.addr == OFS_QUAL)
               rd_data_q <= {6'h00, qual_sel_q};
            else if (bus_i.addr == OFS_STATUS)
               rd_data_q <= {6'h00, pdf_q, to_q};
            else
               rd_data_q <= '0;
         end
      end
   end

   // reset outputs; all asserted through power-on
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rst_q.sys_reset   <= 1'b1;
         rst_q.pc_sp_clear <= 1'b1;  // RULE_17
         rst_q.port_preset <= 1'b1;  // RULE_18
      end
      else if (clk_en)
      begin
         rst_q.sys_reset   <= full_reset;             // RULE_06
         rst_q.pc_sp_clear <= full_reset | sleep_to;  // RULE_07
         rst_q.port_preset <= full_reset;
      end
   end

   assign rd_data_o = rd_data_q;
   assign rst_o     = rst_q;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || !clk_en);

   sequence bad_armed;
      (srst_state_q == RS_IDLE) && (wdt_bad || rst_bad || thr_bad) && !full_reset;
   endsequence

   sequence enter_wait;
      ##1 (srst_state_q == RS_WAIT);
   endsequence

   por_wdt_value_a: assert property ($past(reset) |-> wdt_ctrl_q == WDT_CTRL_POR) // RULE_04
      else $error("watchdog control not at power-on value");
   por_rst_value_a: assert property ($past(reset) |-> rst_ctrl_q == RST_CTRL_POR) // RULE_10
      else $error("reset control not at power-on value");
   bad_code_arm_a: assert property (bad_armed |-> enter_wait) // RULE_03
      else $error("invalid guarded code did not arm soft reset");
   wdt_stop_a: assert property (!wdt_run && !wdt_clear_evt && !full_reset && !sleep_to
                                |=> $stable(wdt_cnt_q)) // RULE_02
      else $error("disabled watchdog counter moved");
   run_ovf_a: assert property (norm_ovf |=> rst_o.sys_reset && to_q) // RULE_06
      else $error("running overflow gave no full reset");
   sleep_ovf_a: assert property (sleep_to |=> rst_o.pc_sp_clear && !rst_o.sys_reset && to_q && pdf_q) // RULE_07
      else $error("sleep overflow handled wrongly");
   count_clear_a: assert property (wdt_clear_evt |=> wdt_cnt_q == '0) // RULE_08
      else $error("clear or halt did not clear counter");
   flag_upper_a: assert property (bus_i.rd && bus_i.addr == OFS_FLAGS |=> rd_data_o[7:4] == 4'h0) // RULE_12
      else $error("flag register upper bits not zero");
   wrf_cause_a: assert property ($rose(flags_q[WRF_BIT]) |-> $past(sw_fire && cause_q[0])) // RULE_05
      else $error("watchdog register flag set without its reset");
   reset_reg_reset_flag_cause_a: assert property ($rose(flags_q[RESET_REG_RESET_FLAG_BIT]) |-> $past(sw_fire && cause_q[1])) // RULE_11
      else $error("reset register flag set without its reset");
   lv_sleep_a: assert property (sleep_idle_i |=> lv_cnt_q == '0) // RULE_16
      else $error("low voltage count moved in sleep");
   lv_flag_a: assert property (lv_fire |=> flags_q[LOW_VOLTAGE_RESET_FLAG_BIT] && rst_o.sys_reset) // RULE_14
      else $error("low voltage reset did not set its flag");

endmodule

// ==== wdrc_top_tb.sv ====
`timescale 1ns/1ps
module wdrc_top_tb;
   import wdrc_pkg::*;

   logic        clk = 1'b0;      // 100 MHz bench clock
   logic        reset = 1'b1;    // power-on reset
   logic        clk_en = 1'b1;   // clock enable
   wdrc_bus_s   bus = '0;        // register bus request
   logic [7:0]  rd_data;         // register read data
   logic        slow_osc = 1'b0; // slow oscillator pin
   logic [2:0]  osc_div = 3'h0;  // one slow tick per 8 clocks
   logic        low_v = 1'b0;    // low supply indication
   logic        sleep = 1'b0;    // core in sleep or idle
   logic        clear_watchdog_instruction = 1'b0;  // clear-watchdog pulse
   logic        halt = 1'b0;     // halt pulse
   wdrc_rst_s   rst;             // reset outputs
   int          n_mismatch = 0;  // mismatches seen
   int          check_count = 0; // comparisons made
   logic [15:0] n;               // cycles until a reset pulse
   logic        s;               // pulse was a full reset
   logic [4:0]  bad_g [4] = '{5'h00, 5'h1F, 5'h0B, 5'h14}; // invalid enable codes
   logic [7:0]  thr_c [4] = '{8'h33, 8'h99, 8'hAA, 8'h55}; // valid thresholds

   // short soft reset delay keeps the run brief
   wdrc_top #(
      .SRESET_TICKS (8'h02)
   ) uut (
      .clk           (clk),
      .reset         (reset),
      .clk_en        (clk_en),
      .bus_i         (bus),
      .rd_data_o     (rd_data),
      .slow_osc_i    (slow_osc),
      .low_voltage_i (low_v),
      .sleep_idle_i  (sleep),
      .clear_watchdog_instruction_i     (clear_watchdog_instruction),
      .halt_i        (halt),
      .rst_o         (rst)
   );

   // clock generator
   always #5 clk = ~clk;

   // slow oscillator: square wave of 8 clock periods
   always @(posedge clk)
   begin
      osc_div <= osc_div + 3'h1;
      slow_osc <= osc_div[2];
   end

   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic test_done;
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   // one-cycle read, data judged in the following cycle
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1;
      chk(rd_data, e);
   endtask

   // clear (h=0) or halt (h=1) pulse
   task automatic pulse(input logic h);
      @(posedge clk);
      if (h)
         halt <= 1'b1;
      else
         clear_watchdog_instruction <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      clear_watchdog_instruction <= 1'b0;
   endtask

   // bounded wait for any reset pulse
   task automatic wait_pulse(input int maxc, output logic [15:0] cnt, output logic sys);
      cnt = '0;
      #1;
      while (cnt < maxc && rst.sys_reset !== 1'b1 && rst.pc_sp_clear !== 1'b1)
      begin
         @(posedge clk);
         #1;
         cnt++;
      end
      sys = rst.sys_reset;
      chk(16'(rst.port_preset), 16'(sys));
      chk(16'(rst.pc_sp_clear), 16'(cnt < maxc));
      repeat (4) @(posedge clk);
   endtask

   // a write strobe while the clock enable is low is dropped
   task automatic t_freeze;
      @(posedge clk);
      clk_en <= 1'b0;
      bus <= '{addr: OFS_RST_CTRL, wdata: 8'hAA, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      clk_en <= 1'b1;
      bus <= '0;
      rdchk(OFS_RST_CTRL, 8'h55);
   endtask

   // power-on values, unmapped and read-only places
   task automatic t_regs;
      rdchk(OFS_WDT_CTRL, 8'h53);
      rdchk(OFS_FLAGS, 8'h00);
      rdchk(OFS_RST_CTRL, 8'h55);
      rdchk(OFS_THRESH, 8'h55);
      rdchk(OFS_QUAL, 8'h01);
      rdchk(OFS_STATUS, 8'h00);
      rdchk(4'hF, 8'h00);
      wr(OFS_FLAGS, 8'hF0);
      rdchk(OFS_FLAGS, 8'h00);
      wr(OFS_STATUS, 8'hFF);
      rdchk(OFS_STATUS, 8'h00);
   endtask

   // awake overflow with the shortest period
   task automatic t_timeout;
      wr(OFS_WDT_CTRL, 8'h50);
      pulse(1'b0);
      wait_pulse(2200, n, s);
      chk(s, 16'h1);
      chk(16'(n >= 2030 && n <= 2065), 16'h1);
      rdchk(OFS_STATUS, 8'h01);
      rdchk(OFS_WDT_CTRL, 8'h53);
   endtask

   // clear and halt keep it quiet; disabled it stays stopped
   task automatic t_clear;
      wr(OFS_WDT_CTRL, 8'h50);
      pulse(1'b0);
      for (int i = 0; i < 4; i++)
      begin
         wait_pulse(1200, n, s);
         chk(n, 16'd1200);
         pulse(i == 3);
      end
      wait_pulse(2200, n, s);
      chk(s, 16'h1);
      wr(OFS_WDT_CTRL, 8'hA8);
      pulse(1'b0);
      wait_pulse(2200, n, s);
      chk(n, 16'd2200);
      pulse(1'b1);
      wait_pulse(2200, n, s);
      chk(n, 16'd2200);
      rdchk(OFS_STATUS, 8'h02);
   endtask

   // overflow in sleep clears pc and sp only
   task automatic t_sleep;
      @(posedge clk);
      sleep <= 1'b1;
      wr(OFS_WDT_CTRL, 8'h50);
      pulse(1'b0);
      wait_pulse(2200, n, s);
      chk(s, 16'h0);
      chk(16'(n >= 2030 && n <= 2065), 16'h1);
      rdchk(OFS_STATUS, 8'h03);
      rdchk(OFS_WDT_CTRL, 8'h50);
      @(posedge clk);
      sleep <= 1'b0;
      wr(OFS_WDT_CTRL, 8'hA8);
   endtask

   // four bad enable codes: all zeros, all ones, one bit off each valid code
   task automatic t_guard;
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_WDT_CTRL, {bad_g[i], 3'h0});
         wait_pulse(200, n, s);
         chk(s, 16'h1);
         chk(16'(n >= 6 && n <= 30), 16'h1);
         rdchk(OFS_FLAGS, 8'h01);
         rdchk(OFS_WDT_CTRL, 8'h53);
         wr(OFS_FLAGS, 8'hFF);
         rdchk(OFS_FLAGS, 8'h01);
         wr(OFS_FLAGS, 8'h00);
         rdchk(OFS_FLAGS, 8'h00);
      end
   endtask

   // reset control: no-op code, then a corrupt one
   task automatic t_rstctl;
      wr(OFS_RST_CTRL, 8'hAA);
      wait_pulse(200, n, s);
      chk(n, 16'd200);
      rdchk(OFS_RST_CTRL, 8'hAA);
      wr(OFS_RST_CTRL, 8'h12);
      wait_pulse(200, n, s);
      chk(s, 16'h1);
      rdchk(OFS_FLAGS, 8'h08);
      rdchk(OFS_RST_CTRL, 8'h55);
      wr(OFS_FLAGS, 8'h00);
   endtask

   // threshold codes: four accepted, others reset
   task automatic t_thresh;
      for (int i = 0; i < 4; i++)
      begin
         wr(OFS_THRESH, thr_c[i]);
         rdchk(OFS_THRESH, thr_c[i]);
      end
      wait_pulse(200, n, s);
      chk(n, 16'd200);
      wr(OFS_THRESH, 8'h00);
      wait_pulse(200, n, s);
      chk(s, 16'h1);
      rdchk(OFS_FLAGS, 8'h02);
      rdchk(OFS_THRESH, 8'h55);
      wr(OFS_FLAGS, 8'h00);
   endtask

   // low voltage: short dip, qualified drop, sleep masking
   task automatic t_lowv;
      wr(OFS_QUAL, 8'h00);
      wr(OFS_THRESH, 8'h33);
      @(posedge clk);
      low_v <= 1'b1;
      repeat (32) @(posedge clk);
      low_v <= 1'b0;
      wait_pulse(200, n, s);
      chk(n, 16'd200);
      @(posedge clk);
      low_v <= 1'b1;
      wait_pulse(300, n, s);
      chk(s, 16'h1);
      chk(16'(n >= 48 && n <= 76), 16'h1);
      low_v <= 1'b0;
      rdchk(OFS_FLAGS, 8'h04);
      rdchk(OFS_THRESH, 8'h33);
      rdchk(OFS_QUAL, 8'h01);
      wr(OFS_FLAGS, 8'h00);
      @(posedge clk);
      sleep <= 1'b1;
      low_v <= 1'b1;
      wait_pulse(400, n, s);
      chk(n, 16'd400);
      sleep <= 1'b0;
      wait_pulse(400, n, s);
      chk(s, 16'h1);
      chk(16'(n >= 240 && n <= 280), 16'h1);
      low_v <= 1'b0;
   endtask

   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      chk(rst, 16'h0007);
      @(posedge clk);
      reset <= 1'b0;
      t_regs;
      t_freeze;
      t_timeout;
      t_clear;
      t_sleep;
      t_guard;
      t_rstctl;
      t_thresh;
      t_lowv;
      test_done;
   end

   // hang guard, well past the expected run length
   initial
   begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      test_done;
   end
endmodule
